//--- inc/supervisor_pkg.sv
// Shared constants for the supervisory reset watchdog and its processor end
package supervisor_pkg;
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned HOLD_PERIOD_MS     = 200;
  localparam int unsigned KICK_TIMEOUT_MS    = 1600;
  localparam int unsigned KICK_MIN_WIDTH_NS  = 50;
  localparam int unsigned PUSH_IMMUNE_NS     = 100;
  localparam int unsigned NS_PER_MS          = 1000000;
  localparam int unsigned TIMEBASE_CYCLES    = NS_PER_MS / CLK_PERIOD_NS;
  localparam int unsigned HOLD_TICKS         = HOLD_PERIOD_MS;
  localparam int unsigned KICK_TIMEOUT_TICKS = KICK_TIMEOUT_MS;
  localparam int unsigned SELF_KICK_NUM      = 7;
  localparam int unsigned SELF_KICK_DEN      = 8;
  localparam int unsigned PUSH_FILTER_CYCLES =
    (PUSH_IMMUNE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned KICK_WIDTH_CYCLES  =
    (KICK_MIN_WIDTH_NS / CLK_PERIOD_NS) > 0 ? KICK_MIN_WIDTH_NS / CLK_PERIOD_NS : 1;
  localparam int unsigned TICK_W             = 12;
  localparam int unsigned BASE_W             = 24;
  localparam int unsigned FILT_W             = 8;
endpackage : supervisor_pkg

//--- inc/supervisor_if.sv
// Link between supervisor and supervised processor
interface supervisor_if;
  logic hold_n;
  logic hold;
  logic push_n;
  logic kick_dev;
  logic kick_dev_oe;
  logic kick_cpu;
  logic kick_cpu_oe;
  logic kick;
  // Strong processor drive beats the weak internal driver
  assign kick = kick_cpu_oe ? kick_cpu : (kick_dev_oe ? kick_dev : 1'b0);

  modport device (output hold_n, output hold, input push_n, output kick_dev, output kick_dev_oe, input kick);
  modport cpu    (input hold_n, input hold, output push_n, output kick_cpu, output kick_cpu_oe);
endinterface : supervisor_if

//--- rtl/supervisory_reset_watchdog.sv
// Supervisory reset generator with watchdog
module supervisory_reset_watchdog #(
  parameter int unsigned TIMEBASE  = supervisor_pkg::TIMEBASE_CYCLES,
  parameter int unsigned HOLD_T    = supervisor_pkg::HOLD_TICKS,
  parameter int unsigned TIMEOUT_T = supervisor_pkg::KICK_TIMEOUT_TICKS
) (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic supply_low_in,
  supervisor_if.device link
);
  import supervisor_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {
    ST_HOLD = 2'b01,
    ST_RUN  = 2'b10
  } hold_state_e;

  hold_state_e          state_reg, state_next;
  logic [1:0]           supply_sync_reg, supply_sync_next;
  logic [BASE_W-1:0]    base_reg, base_next;
  logic [TICK_W-1:0]    hold_cnt_reg, hold_cnt_next;
  logic [TICK_W-1:0]    wd_cnt_reg, wd_cnt_next;
  logic [FILT_W-1:0]    push_cnt_reg, push_cnt_next;
  logic                 push_act_reg, push_act_next;
  logic                 kick_prev_reg, kick_prev_next;
  logic                 hold_n_reg, hold_n_next;
  logic                 kick_dev_reg, kick_dev_next;
  logic                 tick;
  logic                 kick_edge;
  logic                 cause;

  function automatic logic at_count(input logic [TICK_W-1:0] cnt, input int unsigned lim);
    at_count = cnt >= TICK_W'(lim);
  endfunction : at_count

  localparam int unsigned         HOLD_LAST    = HOLD_T - 1;
  localparam int unsigned         WD_LAST      = TIMEOUT_T - 1;
  localparam logic [TICK_W-1:0]   SELF_KICK_AT = TICK_W'((TIMEOUT_T * SELF_KICK_NUM) / SELF_KICK_DEN);

  // ****************************************
  // Time base
  // ****************************************
  always_comb begin
    // Free running tick shared by both timers
    tick      = base_reg == BASE_W'(TIMEBASE - 1);
    base_next = tick ? '0 : base_reg + 1'b1;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      base_reg <= '0;
    end else begin
      base_reg <= base_next;
    end
  end

  // ****************************************
  // Supply flag synchroniser
  // ****************************************
  always_comb begin
    supply_sync_next = {supply_sync_reg[0], supply_low_in};
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      // Starts as supply low, so power-up holds
      supply_sync_reg <= '1;
    end else begin
      supply_sync_reg <= supply_sync_next;
    end
  end

  // ****************************************
  // Kick edge detector
  // ****************************************
  always_comb begin
    // Kick sampled every cycle, so pulses of one cycle count
    kick_prev_next = link.kick;
    kick_edge      = link.kick != kick_prev_reg;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      kick_prev_reg <= 1'b0;
    end else begin
      kick_prev_reg <= kick_prev_next;
    end
  end

  // ****************************************
  // Push filter
  // ****************************************
  always_comb begin
    // Low must persist past immunity width
    if (link.push_n) begin
      push_cnt_next = '0;
      push_act_next = 1'b0;
    end else if (push_cnt_reg >= FILT_W'(PUSH_FILTER_CYCLES)) begin
      push_cnt_next = push_cnt_reg;
      push_act_next = 1'b1;
    end else begin
      push_cnt_next = push_cnt_reg + 1'b1;
      push_act_next = push_act_reg;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      push_cnt_reg <= '0;
      push_act_reg <= 1'b0;
    end else begin
      push_cnt_reg <= push_cnt_next;
      push_act_reg <= push_act_next;
    end
  end

  // ****************************************
  // Hold and watchdog control
  // ****************************************
  always_comb begin
    cause         = supply_sync_reg[1] | push_act_reg;
    state_next    = state_reg;
    hold_cnt_next = hold_cnt_reg;
    wd_cnt_next   = wd_cnt_reg;
    hold_n_next   = hold_n_reg;
    case (state_reg)
      ST_HOLD: begin
        wd_cnt_next = '0;
        hold_n_next = 1'b0;
        if (cause) begin
          hold_cnt_next = '0;
        end else if (tick) begin
          if (at_count(hold_cnt_reg, HOLD_LAST)) begin
            state_next  = ST_RUN;
            hold_n_next = 1'b1;
          end else begin
            hold_cnt_next = hold_cnt_reg + 1'b1;
          end
        end
      end
      ST_RUN: begin
        hold_cnt_next = '0;
        if (cause || (tick && at_count(wd_cnt_reg, WD_LAST))) begin
          state_next  = ST_HOLD;
          hold_n_next = 1'b0;
          wd_cnt_next = '0;
        end else if (kick_edge) begin
          wd_cnt_next = '0;
        end else if (tick) begin
          wd_cnt_next = wd_cnt_reg + 1'b1;
        end
      end
      default: begin
        state_next  = ST_HOLD;
        hold_n_next = 1'b0;
      end
    endcase
    // Weak self drive from the watchdog count
    kick_dev_next = wd_cnt_next >= SELF_KICK_AT;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_reg    <= ST_HOLD;
      hold_cnt_reg <= '0;
      wd_cnt_reg   <= '0;
      hold_n_reg   <= 1'b0;
      kick_dev_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      hold_cnt_reg <= hold_cnt_next;
      wd_cnt_reg   <= wd_cnt_next;
      hold_n_reg   <= hold_n_next;
      kick_dev_reg <= kick_dev_next;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link.hold_n      = hold_n_reg;
  // Active-high copy for parts that want it
  assign link.hold        = ~hold_n_reg;
  assign link.kick_dev    = kick_dev_reg;
  assign link.kick_dev_oe = 1'b1;
endmodule : supervisory_reset_watchdog

//--- rtl/supervised_cpu_end.sv
// Processor side: drives the kick line and push button
module supervised_cpu_end (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic kick_enable_in,
  input  wire logic kick_raise_in,
  input  wire logic kick_lower_in,
  input  wire logic push_in,
  output logic      cpu_held_out,
  supervisor_if.cpu link
);
  import supervisor_pkg::*;

  logic kick_reg, kick_next;
  logic oe_reg, oe_next;
  logic held_reg, held_next;

  // ****************************************
  // Kick drive
  // ****************************************
  always_comb begin
    kick_next = kick_reg;
    if (kick_raise_in) begin
      kick_next = 1'b1;
    end else if (kick_lower_in) begin
      kick_next = 1'b0;
    end
    oe_next   = kick_enable_in;
    held_next = ~link.hold_n;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      kick_reg <= 1'b0;
      oe_reg   <= 1'b0;
      held_reg <= 1'b1;
    end else begin
      kick_reg <= kick_next;
      oe_reg   <= oe_next;
      held_reg <= held_next;
    end
  end

  assign link.kick_cpu    = kick_reg;
  assign link.kick_cpu_oe = oe_reg;
  assign link.push_n      = ~push_in;
  assign cpu_held_out     = held_reg;
endmodule : supervised_cpu_end

//--- verif/supervisor_monitor.sv
// Assertions on the supervisor link, taken at the shortened timing
module supervisor_monitor (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic supply_low_in,
  input wire logic hold_n,
  input wire logic hold,
  input wire logic push_n,
  input wire logic kick,
  input wire logic kick_dev,
  input wire logic kick_cpu_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  int low_reg, free_reg, wd_reg, push_reg;
  logic kick_reg;
  // ****
  // Helper counters
  // ****
  always_ff @(posedge clk_in) begin
    kick_reg <= kick;
    low_reg <= (!reset_n_in || hold_n) ? 0 : low_reg + 1;
    free_reg <= (!reset_n_in || !push_n || supply_low_in) ? 0 : free_reg + 1;
    wd_reg <= (!reset_n_in || !hold_n || kick != kick_reg) ? 0 : wd_reg + 1;
    push_reg <= (!reset_n_in || push_n) ? 0 : push_reg + 1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  a_hold_inverse: assert property (hold == !hold_n)
    else $error("active-high hold not inverse");
  a_hold_min_len: assert property ($rose(hold_n) |-> low_reg >= 190)
    else $error("hold shorter than hold period");
  a_release_after_cause: assert property ($rose(hold_n) |-> free_reg >= 190)
    else $error("hold released too soon after cause");
  a_push_holds: assert property (push_reg > 14 |-> !hold_n)
    else $error("push low without hold");
  a_supply_holds: assert property (supply_low_in [*5] |-> !hold_n)
    else $error("supply low without hold");
  a_wd_bound: assert property (wd_reg <= 1610)
    else $error("stuck kick without hold");
  a_wd_not_early: assert property ($fell(hold_n) && push_n && !supply_low_in |-> wd_reg >= 1585)
    else $error("watchdog fired early");
  a_self_kick: assert property ($rose(kick_dev) && !kick_cpu_oe |-> wd_reg >= 1380 && wd_reg <= 1410)
    else $error("self kick at wrong time");
endmodule : supervisor_monitor

//--- verif/tb_supervisory_reset_watchdog.sv
// Self-checking bench for both ends of the supervisor link
module tb_supervisory_reset_watchdog;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, reset_n_in, supply_low_in, kick_enable_in, kick_raise_in, kick_lower_in, push_in, cpu_held_out;
  int mismatches, checks_done, cycles, n;
  supervisor_if link ();
  supervisory_reset_watchdog #(.TIMEBASE(10), .HOLD_T(20), .TIMEOUT_T(160)) u_supervisory_reset_watchdog (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .supply_low_in(supply_low_in), .link(link.device));
  supervised_cpu_end u_supervised_cpu_end (.clk_in(clk_in), .reset_n_in(reset_n_in), .kick_enable_in(kick_enable_in),
    .kick_raise_in(kick_raise_in), .kick_lower_in(kick_lower_in), .push_in(push_in), .cpu_held_out(cpu_held_out),
    .link(link.cpu));
  supervisor_monitor u_supervisor_monitor (.clk_in(clk_in), .reset_n_in(reset_n_in), .supply_low_in(supply_low_in),
    .hold_n(link.hold_n), .hold(link.hold), .push_n(link.push_n), .kick(link.kick), .kick_dev(link.kick_dev),
    .kick_cpu_oe(link.kick_cpu_oe));
  // ****
  // Clock, timeout and tasks
  // ****
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic check_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0b seen %0b", what, exp, got);
    end
  endtask : check_bit
  task automatic check_span(input string what, input int lo, input int hi, input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : check_span
  task automatic wait_hold(input logic lvl, input int lim, output int k);
    k = 0;
    while (link.hold_n !== lvl && k < lim) begin
      @(negedge clk_in);
      k++;
    end
  endtask : wait_hold
  task automatic kick_pulse();
    kick_raise_in = 1'b1;
    @(negedge clk_in);
    kick_raise_in = 1'b0;
    kick_lower_in = 1'b1;
    @(negedge clk_in);
    kick_lower_in = 1'b0;
  endtask : kick_pulse
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  // ****
  // Tests
  // ****
  initial begin
    {reset_n_in, supply_low_in, kick_enable_in, kick_raise_in, kick_lower_in, push_in} = '0;
    mismatches = 0;
    checks_done = 0;
    cycles = 0;
    repeat (10) @(negedge clk_in);
    reset_n_in = 1'b1;
    check_bit("hold_n", 1'b0, link.hold_n);
    wait_hold(1'b1, 400, n);
    check_span("power-up hold", 190, 215, n);
    @(negedge clk_in);
    check_bit("hold", 1'b0, link.hold);
    check_bit("cpu_held_out", 1'b0, cpu_held_out);
    $display("test power_up done");
    kick_enable_in = 1'b1;
    repeat (8) begin
      repeat (700) @(negedge clk_in);
      kick_pulse();
    end
    check_bit("hold_n", 1'b1, link.hold_n);
    wait_hold(1'b0, 2000, n);
    check_span("kick timeout", 1585, 1615, n);
    wait_hold(1'b1, 400, n);
    check_span("watchdog hold", 190, 215, n);
    wait_hold(1'b0, 2000, n);
    check_span("timeout after hold", 1585, 1615, n);
    wait_hold(1'b1, 400, n);
    $display("test watchdog done");
    kick_enable_in = 1'b0;
    repeat (5000) @(negedge clk_in);
    check_bit("hold_n", 1'b1, link.hold_n);
    check_bit("kick_dev_oe", 1'b1, link.kick_dev_oe);
    $display("test floating done");
    push_in = 1'b1;
    repeat (5) @(negedge clk_in);
    push_in = 1'b0;
    repeat (20) @(negedge clk_in);
    check_bit("hold_n", 1'b1, link.hold_n);
    repeat (4) begin
      push_in = 1'b1;
      repeat (3) @(negedge clk_in);
      push_in = 1'b0;
      repeat (3) @(negedge clk_in);
    end
    push_in = 1'b1;
    repeat (40) @(negedge clk_in);
    check_bit("hold_n", 1'b0, link.hold_n);
    check_bit("cpu_held_out", 1'b1, cpu_held_out);
    push_in = 1'b0;
    wait_hold(1'b1, 400, n);
    check_span("push hold", 195, 230, n);
    $display("test push done");
    supply_low_in = 1'b1;
    repeat (20) @(negedge clk_in);
    supply_low_in = 1'b0;
    repeat (100) @(negedge clk_in);
    supply_low_in = 1'b1;
    repeat (20) @(negedge clk_in);
    supply_low_in = 1'b0;
    wait_hold(1'b1, 400, n);
    check_span("supply hold", 195, 215, n);
    $display("test supply done");
    end_of_test();
  end
endmodule : tb_supervisory_reset_watchdog
